// [rtl/wakeup_event_config_regs.sv]
// Purpose: Core-side wake-up event and host configuration base registers
// Assumes: AXI4-Lite slave, 25 MHz clk, all inputs synchronous to clk
// Notes:   Interrupt vector feeds the wake-up input unit, level high
//
// Contract
// - Base low byte bit 0 always zero
// - Base high byte is separate RW register
// - Base bytes cleared only on power-up
// - Interrupt enables cleared on warm reset
// - Interrupts level high, drop on clear
// - Alarm interrupt gated by enable bit 0
// - Bits 5..1 enable sleep request interrupts
// - S0 interrupt enabled by any S1..S5 enable
// - Bit 6 enables button mode change interrupt
// - Bit 7 enables supply off interrupt
// - Status set by same host wake events
// - Status cleared on power-up and software reset
// - One clears status bit, zero keeps
// - Status bits 0,1,3 ring; 2,4,5 reserved
// - Mode clear: bit 6 on rising status
// - Mode set: bit 6 on host write
// - Bit 7 latches module IRQ until cleared
// - Alarm flag set on rising alarm edge
// - Sleep flags set by host, one-clear
`timescale 1ns/100ps
`include "wecr_map.svh"

module wakeup_event_config_regs (
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     warmResetn,
    input  wire logic                     hostSwResetn,
    input  wire wecr_pkg::wecr_host_evt_t  hostEvt,
    input  wire wecr_pkg::wecr_power_evt_t powerEvt,
    input  wire logic [19:0]              awaddr,
    input  wire logic                     awvalid,
    output logic                          awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output logic                          wready,
    output logic [1:0]                    bresp,
    output logic                          bvalid,
    input  wire logic                     bready,
    input  wire logic [19:0]              araddr,
    input  wire logic                     arvalid,
    output logic                          arready,
    output logic [31:0]                   rdata,
    output logic [1:0]                    rresp,
    output logic                          rvalid,
    input  wire logic                     rready,
    output logic [15:0]                   hostCfgBase,
    output logic [7:0]                    coreIrq
);

    // Address to register selector, shared by read and write paths
    function automatic wecr_pkg::wecr_sel_t decode(input logic [19:0] addr);
        logic [15:0] idx;
        idx = 16'(addr >> 2);
        decode = wecr_pkg::WECR_SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            unique case (idx)
                `WECR_IDX_BASE_LOW:    decode = wecr_pkg::WECR_SEL_BASE_LOW;
                `WECR_IDX_BASE_HIGH:   decode = wecr_pkg::WECR_SEL_BASE_HIGH;
                `WECR_IDX_IRQ_ENABLE:  decode = wecr_pkg::WECR_SEL_IRQ_ENABLE;
                `WECR_IDX_HOST_STATUS: decode = wecr_pkg::WECR_SEL_HOST_STATUS;
                `WECR_IDX_EVENT_FLAGS: decode = wecr_pkg::WECR_SEL_EVENT_FLAGS;
                `WECR_IDX_EVENT_CTRL:  decode = wecr_pkg::WECR_SEL_EVENT_CTRL;
                default:               decode = wecr_pkg::WECR_SEL_NONE;
            endcase
        end
    endfunction : decode

    // Sticky flag update: hardware set wins over one-clear
    function automatic logic [7:0] stickyNext(input logic [7:0] cur,
                                              input logic [7:0] set,
                                              input logic [7:0] clr);
        stickyNext = (cur & ~clr) | set;
    endfunction : stickyNext

    // Register storage
    logic [7:0]  baseLow;          // Host config base, low byte
    logic [7:0]  baseHigh;         // Host config base, high byte
    logic [7:0]  irqEnable;        // Power event interrupt enables
    logic [7:0]  hostStatus;       // Host event status
    logic [7:0]  eventFlags;       // Alarm and sleep request flags
    logic        swEventMode;      // Software event mode
    logic        buttonChg;        // Button mode changed flag
    logic        supplyOffFlag;    // Supply off flag

    // Edge detection history
    logic        alarmPrev;        // Previous alarm level
    logic        swStatus6Prev;    // Previous host wake status bit 6
    logic        buttonPrev;       // Previous button mode level

    // Bus holding registers
    logic [19:0] wrAddr;           // Captured write address
    logic [7:0]  wrData;           // Captured write data low byte
    logic        wrLane0;          // Captured byte lane 0 strobe

    // Write decode
    wecr_pkg::wecr_sel_t wrSel;
    wecr_pkg::wecr_sel_t rdSel;
    logic        doWrite;          // Both halves held, write now
    logic        wrByte;           // Write touches byte lane 0
    logic [7:0]  wrOnes;           // One-write mask for W1C fields

    assign wrSel   = decode(wrAddr);
    assign rdSel   = decode(araddr);
    assign doWrite = !awready && !wready && !bvalid;
    assign wrByte  = doWrite && wrLane0;
    assign wrOnes  = wrByte ? wrData : 8'h00;

    // Per-register write strobes
    logic weBaseLow;
    logic weBaseHigh;
    logic weIrqEnable;
    logic weEventCtrl;
    logic [7:0] clrHostStatus;     // One-clear mask for host status
    logic [7:0] clrEventFlags;     // One-clear mask for event flags
    logic [7:0] clrEventCtrl;      // One-clear mask for event control

    assign weBaseLow     = wrByte && (wrSel == wecr_pkg::WECR_SEL_BASE_LOW);
    assign weBaseHigh    = wrByte && (wrSel == wecr_pkg::WECR_SEL_BASE_HIGH);
    assign weIrqEnable   = wrByte && (wrSel == wecr_pkg::WECR_SEL_IRQ_ENABLE);
    assign weEventCtrl   = wrByte && (wrSel == wecr_pkg::WECR_SEL_EVENT_CTRL);
    assign clrHostStatus = (wrSel == wecr_pkg::WECR_SEL_HOST_STATUS) ? wrOnes : 8'h00;
    assign clrEventFlags = (wrSel == wecr_pkg::WECR_SEL_EVENT_FLAGS) ? wrOnes : 8'h00;
    assign clrEventCtrl  = weEventCtrl ? wrData : 8'h00;

    // Host event status set terms
    logic [7:0] setHostStatus;
    logic       swEventSet;

    assign swEventSet = swEventMode ? hostEvt.swWrite1
                                    : (hostEvt.swStatus6 && !swStatus6Prev);
    always_comb begin
        setHostStatus                  = 8'h00;
        setHostStatus[`WECR_HS_RING1]  = hostEvt.ring1;
        setHostStatus[`WECR_HS_RING2]  = hostEvt.ring2;
        setHostStatus[`WECR_HS_RING]   = hostEvt.ring;
        setHostStatus[`WECR_HS_SWEVT]  = swEventSet;
        setHostStatus[`WECR_HS_MODIRQ] = hostEvt.modIrq;
    end

    // Event flag set terms
    logic [7:0] setEventFlags;

    always_comb begin
        setEventFlags                 = 8'h00;
        setEventFlags[`WECR_EF_ALARM] = powerEvt.alarm && !alarmPrev;
        setEventFlags[`WECR_EF_S0]    = powerEvt.sleepReq[0];
        setEventFlags[5:1]            = powerEvt.sleepReq[5:1];
    end

    // Next register values
    logic [7:0] next_hostStatus;
    logic [7:0] next_eventFlags;
    logic       next_buttonChg;
    logic       next_supplyOff;

    assign next_hostStatus = stickyNext(hostStatus, setHostStatus, clrHostStatus)
                             & `WECR_HS_IMPL_MASK;
    assign next_eventFlags = stickyNext(eventFlags, setEventFlags, clrEventFlags)
                             & `WECR_EF_IMPL_MASK;
    assign next_buttonChg  = (powerEvt.buttonMode != buttonPrev)
                             || (buttonChg && !clrEventCtrl[`WECR_EC_BUTTON_CHG]);
    assign next_supplyOff  = powerEvt.supplyOff
                             || (supplyOffFlag && !clrEventCtrl[`WECR_EC_SUPPLY_OFF]);

    // Interrupt vector toward the wake-up input unit
    logic [7:0] next_coreIrq;
    logic       sleepAnyEn;

    assign sleepAnyEn = |irqEnable[`WECR_EN_SLEEP_HI:`WECR_EN_SLEEP_LO];
    always_comb begin
        next_coreIrq                   = 8'h00;
        next_coreIrq[`WECR_EN_ALARM]   = irqEnable[`WECR_EN_ALARM]
                                         && eventFlags[`WECR_EF_ALARM];
        next_coreIrq[5:1]              = irqEnable[5:1] & eventFlags[5:1];
        next_coreIrq[`WECR_EN_SLEEP_LO] = next_coreIrq[`WECR_EN_SLEEP_LO]
                                         || (sleepAnyEn && eventFlags[`WECR_EF_S0]);
        next_coreIrq[`WECR_EN_BUTTON]  = irqEnable[`WECR_EN_BUTTON] && buttonChg;
        next_coreIrq[`WECR_EN_SUPPLY]  = irqEnable[`WECR_EN_SUPPLY] && supplyOffFlag;
    end

    // Read data mux
    logic [7:0] rdByte;
    logic       rdHit;

    assign rdHit = (rdSel != wecr_pkg::WECR_SEL_NONE);
    always_comb begin
        rdByte = 8'h00;
        unique case (rdSel)
            wecr_pkg::WECR_SEL_BASE_LOW:    rdByte = baseLow;
            wecr_pkg::WECR_SEL_BASE_HIGH:   rdByte = baseHigh;
            wecr_pkg::WECR_SEL_IRQ_ENABLE:  rdByte = irqEnable;
            wecr_pkg::WECR_SEL_HOST_STATUS: rdByte = hostStatus;
            wecr_pkg::WECR_SEL_EVENT_FLAGS: rdByte = eventFlags;
            wecr_pkg::WECR_SEL_EVENT_CTRL:  rdByte = {4'h0, powerEvt.buttonMode, supplyOffFlag,
                                                      buttonChg, swEventMode};
            wecr_pkg::WECR_SEL_NONE:        rdByte = 8'h00;
        endcase
    end

    // Base address: power-up reset only
    always_ff @(posedge clk) begin
        if (!resetn) begin
            baseLow  <= `WECR_RST_BYTE;
            baseHigh <= `WECR_RST_BYTE;
        end else begin
            if (weBaseLow) begin
                baseLow <= {wrData[7:1], 1'b0};
            end
            if (weBaseHigh) begin
                baseHigh <= wrData;
            end
        end
    end

    // Interrupt enables: warm reset too
    always_ff @(posedge clk) begin
        if (!resetn || !warmResetn) begin
            irqEnable   <= `WECR_RST_BYTE;
            swEventMode <= 1'b0;
        end else if (weEventCtrl) begin
            swEventMode <= wrData[`WECR_EC_SWMODE];
        end else if (weIrqEnable) begin
            irqEnable <= wrData;
        end
    end

    // Host event status: power-up or host software reset
    always_ff @(posedge clk) begin
        if (!resetn || !hostSwResetn) begin
            hostStatus <= `WECR_RST_BYTE;
        end else begin
            hostStatus <= next_hostStatus;
        end
    end

    // Power event flags and edge history
    always_ff @(posedge clk) begin
        if (!resetn) begin
            eventFlags    <= `WECR_RST_BYTE;
            buttonChg     <= 1'b0;
            supplyOffFlag <= 1'b0;
            alarmPrev     <= 1'b0;
            swStatus6Prev <= 1'b0;
            buttonPrev    <= 1'b0;
        end else begin
            eventFlags    <= next_eventFlags;
            buttonChg     <= next_buttonChg;
            supplyOffFlag <= next_supplyOff;
            alarmPrev     <= powerEvt.alarm;
            swStatus6Prev <= hostEvt.swStatus6;
            buttonPrev    <= powerEvt.buttonMode;
        end
    end

    // Interrupt and base outputs, registered
    always_ff @(posedge clk) begin
        if (!resetn) begin
            coreIrq     <= 8'h00;
            hostCfgBase <= 16'h0000;
        end else begin
            coreIrq     <= next_coreIrq;
            hostCfgBase <= {baseHigh, baseLow};
        end
    end

    // Write address channel
    always_ff @(posedge clk) begin
        if (!resetn) begin
            awready <= 1'b1;
            wrAddr  <= 20'h00000;
        end else if (awvalid && awready) begin
            awready <= 1'b0;
            wrAddr  <= awaddr;
        end else if (bvalid && bready) begin
            awready <= 1'b1;
        end
    end

    // Write data channel
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wready  <= 1'b1;
            wrData  <= 8'h00;
            wrLane0 <= 1'b0;
        end else if (wvalid && wready) begin
            wready  <= 1'b0;
            wrData  <= wdata[7:0];
            wrLane0 <= wstrb[0];
        end else if (bvalid && bready) begin
            wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bvalid <= 1'b0;
            bresp  <= `WECR_RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= (wrSel == wecr_pkg::WECR_SEL_NONE) ? `WECR_RESP_SLVERR : `WECR_RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read channel: data captured with the address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `WECR_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h000000, rdByte};
            rresp   <= rdHit ? `WECR_RESP_OKAY : `WECR_RESP_SLVERR;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end

endmodule : wakeup_event_config_regs

// [rtl/wecr_map.svh]
// Purpose: Register indexes, field positions and reset values of the wake-up event registers
// Assumes: Byte address on the bus is four times the register index
// Notes:   Definitions only
`ifndef WECR_MAP_SVH
`define WECR_MAP_SVH

// Register indexes
`define WECR_IDX_BASE_LOW    16'hFCC8
`define WECR_IDX_BASE_HIGH   16'hFCCA
`define WECR_IDX_IRQ_ENABLE  16'hFCCC
`define WECR_IDX_HOST_STATUS 16'hFCCE
`define WECR_IDX_EVENT_FLAGS 16'hFCD2
`define WECR_IDX_EVENT_CTRL  16'hFCD4

// Interrupt enable fields
`define WECR_EN_ALARM        0
`define WECR_EN_SLEEP_LO     1
`define WECR_EN_SLEEP_HI     5
`define WECR_EN_BUTTON       6
`define WECR_EN_SUPPLY       7

// Host event status fields
`define WECR_HS_RING1        0
`define WECR_HS_RING2        1
`define WECR_HS_RING         3
`define WECR_HS_SWEVT        6
`define WECR_HS_MODIRQ       7
`define WECR_HS_IMPL_MASK    8'hCB

// Event flag fields
`define WECR_EF_ALARM        0
`define WECR_EF_S0           6
`define WECR_EF_IMPL_MASK    8'h7F

// Event control fields
`define WECR_EC_SWMODE       0
`define WECR_EC_BUTTON_CHG   1
`define WECR_EC_SUPPLY_OFF   2
`define WECR_EC_BUTTON_LVL   3

// Reset values
`define WECR_RST_BYTE        8'h00

// Bus answers
`define WECR_RESP_OKAY       2'h0
`define WECR_RESP_SLVERR     2'h2

`endif

// [rtl/wecr_pkg.sv]
// Purpose: Types shared by the wake-up event register block
// Assumes: Constants live in wecr_map.svh
// Notes:   Event inputs travel as packed structs
package wecr_pkg;

    // Host-side wake events, each a one-cycle pulse except swStatus6
    typedef struct packed {
        logic ring1;        // Ring indicator 1 event
        logic ring2;        // Ring indicator 2 event
        logic ring;         // Ring detection event
        logic modIrq;       // Module IRQ event
        logic swStatus6;    // Level of host wake status bit 6
        logic swWrite1;     // Host wrote one to host wake status bit 6
    } wecr_host_evt_t;

    // Power-state inputs from the host domain
    typedef struct packed {
        logic       alarm;      // RTC alarm output level
        logic [5:0] sleepReq;   // Host one-writes to host wake state, S5..S0
        logic       buttonMode; // Button mode mirror level
        logic       supplyOff;  // Host wrote one to supply-off bit, pulse
    } wecr_power_evt_t;

    // Register selector
    typedef enum logic [2:0] {
        WECR_SEL_NONE,
        WECR_SEL_BASE_LOW,
        WECR_SEL_BASE_HIGH,
        WECR_SEL_IRQ_ENABLE,
        WECR_SEL_HOST_STATUS,
        WECR_SEL_EVENT_FLAGS,
        WECR_SEL_EVENT_CTRL
    } wecr_sel_t;

endpackage : wecr_pkg

// [sim/testbench.sv]
// Purpose: Self-checking bench of the wake-up event registers
// Assumes: AXI4-Lite master, one access at a time
// Notes:   Integer model predicts every register read and the irq vector
`timescale 1ns/100ps
`include "wecr_map.svh"
module testbench;
    localparam logic [19:0] A_LO = 20'(`WECR_IDX_BASE_LOW) << 2;
    localparam logic [19:0] A_HI = 20'(`WECR_IDX_BASE_HIGH) << 2;
    localparam logic [19:0] A_EN = 20'(`WECR_IDX_IRQ_ENABLE) << 2;
    localparam logic [19:0] A_HS = 20'(`WECR_IDX_HOST_STATUS) << 2;
    localparam logic [19:0] A_FL = 20'(`WECR_IDX_EVENT_FLAGS) << 2;
    localparam logic [19:0] A_CT = 20'(`WECR_IDX_EVENT_CTRL) << 2;
    localparam int HBIT[4]  = '{1, 2, 8, 128};   // Matching status bits
    logic        clk, resetn, warmResetn, hostSwResetn;
    logic [19:0] awaddr, araddr;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] wdata, rdata, rnd;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [15:0] hostCfgBase;
    logic [7:0]  coreIrq;
    wecr_pkg::wecr_host_evt_t  hostEvt;
    wecr_pkg::wecr_power_evt_t powerEvt;
    int num_errors, n_compared, mLo, mHi, mEn, mHs, mFl, mCtl;

    wakeup_event_config_regs u_dut (.clk(clk), .resetn(resetn), .warmResetn(warmResetn),
        .hostSwResetn(hostSwResetn), .hostEvt(hostEvt), .powerEvt(powerEvt), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hostCfgBase(hostCfgBase), .coreIrq(coreIrq));
    wecr_host_model u_host (.clk(clk), .hostEvt(hostEvt), .powerEvt(powerEvt));

    // Free-running 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // Expected irq vector from the model
    function automatic logic [7:0] expIrq();
        int g;
        g = mFl & mEn & 63;
        if ((mFl & 64) != 0 && (mEn & 62) != 0) g |= 2;
        if ((mCtl & 2) != 0 && (mEn & 64) != 0) g |= 64;
        if ((mCtl & 4) != 0 && (mEn & 128) != 0) g |= 128;
        return 8'(g);
    endfunction : expIrq

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [19:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        wstrb <= s;
        {awvalid, wvalid, bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while ((awvalid && !awready) || (wvalid && !wready));
        do @(posedge clk); while (!bvalid);
        bready <= 1'b0;
        chk(bresp, er);
    endtask : wr

    task automatic rd(input logic [19:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rready <= 1'b0;
        chk(rdata, {24'h000000, e});
        chk(rresp, er);
    endtask : rd

    // Model update, then the bus write
    task automatic put(input logic [19:0] a, input int d);
        case (a)
            A_LO: mLo = d & 254;
            A_HI: mHi = d & 255;
            A_EN: mEn = d & 255;
            A_HS: mHs &= ~d;
            A_FL: mFl &= ~d;
            default: mCtl = (d & 1) | (mCtl & ~d & 6);
        endcase
        wr(a, 8'(d), 4'h1, `WECR_RESP_OKAY);
    endtask : put

    task automatic get(input logic [19:0] a);
        int e;
        case (a)
            A_LO: e = mLo;
            A_HI: e = mHi;
            A_EN: e = mEn;
            A_HS: e = mHs;
            A_FL: e = mFl;
            default: e = mCtl;
        endcase
        rd(a, 8'(e), `WECR_RESP_OKAY);
    endtask : get

    task automatic irqChk();
        repeat (3) @(posedge clk);
        chk(coreIrq, expIrq());
    endtask : irqChk

    task automatic warm();
        @(posedge clk);
        warmResetn <= 1'b0;
        @(posedge clk);
        warmResetn <= 1'b1;
        mEn = 0;
        mCtl &= 6;
    endtask : warm

    task automatic stop_test();
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        stop_test();
    end

    // Main sequence
    initial begin
        {resetn, warmResetn, hostSwResetn} = 3'b000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        {awaddr, araddr, wdata, wstrb} = '0;
        rnd = 32'h2A7EE2BD;
        repeat (6) @(posedge clk);
        {resetn, warmResetn, hostSwResetn} <= 3'b111;
        for (int i = 0; i < 4; i++) get(A_LO + 20'(i * 8));
        rd(20'h3F324, 8'h00, `WECR_RESP_SLVERR);
        wr(20'h3F32C, 8'hFF, 4'h1, `WECR_RESP_SLVERR);
        wr(A_HI, 8'hAA, 4'h0, `WECR_RESP_OKAY);
        repeat (6) begin
            rnd = lfsr(rnd);
            for (int j = 0; j < 3; j++) put(A_LO + 20'(j * 8), int'(rnd >> (j * 8)) & 255);
            for (int j = 0; j < 3; j++) get(A_LO + 20'(j * 8));
            chk(hostCfgBase, mHi * 256 + mLo);
        end
        warm();
        get(A_EN);
        chk(hostCfgBase, mHi * 256 + mLo);
        for (int i = 0; i < 4; i++) begin
            u_host.drive(1'b1, 9'(32 >> i), 1'b1, 1'b1);
            mHs |= HBIT[i];
            get(A_HS);
        end
        put(A_HS, 8'h00);
        get(A_HS);
        put(A_HS, 8'h81);
        get(A_HS);
        put(A_HS, 8'h34);
        get(A_HS);
        u_host.drive(1'b1, 9'h002, 1'b1, 1'b0);
        mHs |= 64;
        get(A_HS);
        put(A_HS, 8'h40);
        u_host.drive(1'b1, 9'h001, 1'b1, 1'b1);
        get(A_HS);
        put(A_CT, 8'h01);
        get(A_CT);
        u_host.drive(1'b1, 9'h001, 1'b1, 1'b1);
        mHs |= 64;
        get(A_HS);
        u_host.drive(1'b1, 9'h002, 1'b0, 1'b0);
        @(posedge clk);
        hostSwResetn <= 1'b0;
        @(posedge clk);
        hostSwResetn <= 1'b1;
        mHs = 0;
        get(A_HS);
        get(A_HI);
        put(A_EN, 8'h01);
        u_host.drive(1'b0, 9'h100, 1'b1, 1'b0);
        mFl |= 1;
        irqChk();
        put(A_FL, 8'h01);
        irqChk();
        u_host.drive(1'b0, 9'h100, 1'b0, 1'b0);
        for (int k = 1; k < 6; k++) begin
            put(A_EN, 1 << k);
            u_host.drive(1'b0, 9'(4 << k), 1'b1, 1'b1);
            mFl |= 1 << k;
            irqChk();
            get(A_FL);
            put(A_FL, 1 << k);
            irqChk();
        end
        put(A_EN, 8'h08);
        u_host.drive(1'b0, 9'h004, 1'b1, 1'b1);
        mFl |= 64;
        irqChk();
        put(A_EN, 8'h40);
        irqChk();
        u_host.drive(1'b0, 9'h002, 1'b1, 1'b0);
        mCtl |= 2;
        irqChk();
        put(A_CT, 8'h02);
        irqChk();
        put(A_EN, 8'h80);
        u_host.drive(1'b0, 9'h001, 1'b1, 1'b1);
        mCtl |= 4;
        irqChk();
        put(A_EN, 8'hFF);
        irqChk();
        warm();
        irqChk();
        stop_test();
    end
endmodule : testbench

// [sim/wecr_chk.sv]
// Purpose: Port-level checks of the wake-up event registers
// Assumes: A write lands one edge after both halves are taken
// Notes:   Enable register is shadowed from bus traffic
`timescale 1ns/100ps
module wecr_chk (
    input wire logic                      clk,
    input wire logic                      resetn,
    input wire logic                      warmResetn,
    input wire wecr_pkg::wecr_power_evt_t powerEvt,
    input wire logic [19:0]               awaddr,
    input wire logic                      awvalid,
    input wire logic                      awready,
    input wire logic [31:0]               wdata,
    input wire logic [3:0]                wstrb,
    input wire logic                      wvalid,
    input wire logic                      wready,
    input wire logic                      bvalid,
    input wire logic                      bready,
    input wire logic [15:0]               hostCfgBase,
    input wire logic [7:0]                coreIrq
);
    logic [19:0] pAddr;   // Captured address
    logic [7:0]  pData;   // Captured byte
    logic        pStrb;   // Byte lane 0 enabled
    logic        hA, hW;  // Halves taken
    logic [7:0]  shEn;    // Shadow enables
    logic [7:0]  enPast;  // Shadow one edge ago
    // Bit 1 also passes the S0 request
    wire [7:0] okNow  = {shEn[7:2], shEn[1] | (|shEn[5:2]), shEn[0]};
    wire [7:0] okPast = {enPast[7:2], enPast[1] | (|enPast[5:2]), enPast[0]};

    // Follow completed writes to the enable register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            hA     <= 1'b0;
            hW     <= 1'b0;
            shEn   <= 8'h00;
            enPast <= 8'h00;
        end else begin
            enPast <= shEn;
            if (awvalid && awready) begin
                hA    <= 1'b1;
                pAddr <= awaddr;
            end
            if (wvalid && wready) begin
                hW    <= 1'b1;
                pData <= wdata[7:0];
                pStrb <= wstrb[0];
            end
            if (hA && hW) begin
                hA <= 1'b0;
                hW <= 1'b0;
                if (pAddr == 20'h3F330 && pStrb)
                    shEn <= pData;
            end
            if (!warmResetn)
                shEn <= 8'h00;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    base_even_a: assert property (hostCfgBase[0] == 1'b0)
        else $error("base bit 0 set");
    base_reset_a: assert property ($rose(resetn) |-> hostCfgBase == 16'h0000)
        else $error("base not cleared");
    base_warm_a: assert property (!warmResetn |=> $stable(hostCfgBase))
        else $error("base lost on warm reset");
    warm_quiet_a: assert property (!warmResetn |=> ##1 coreIrq == 8'h00)
        else $error("irq after warm reset");
    irq_masked_a: assert property ((coreIrq & ~(okNow | okPast)) == 8'h00)
        else $error("irq without enable");
    alarm_irq_a: assert property (shEn[0] && $rose(powerEvt.alarm) ##1 shEn[0] |=> coreIrq[0])
        else $error("alarm irq missing");
    sleep_irq_a: assert property ((|(powerEvt.sleepReq[5:1] & shEn[5:1])) ##1 $stable(shEn) |=> |coreIrq[5:1])
        else $error("sleep irq missing");
    s0_irq_a: assert property (powerEvt.sleepReq[0] && (|shEn[5:1]) ##1 $stable(shEn) |=> coreIrq[1])
        else $error("S0 irq missing");
    button_irq_a: assert property ($changed(powerEvt.buttonMode) && shEn[6] ##1 shEn[6] |=> coreIrq[6])
        else $error("button irq missing");
    supply_irq_a: assert property (powerEvt.supplyOff && shEn[7] ##1 shEn[7] |=> coreIrq[7])
        else $error("supply irq missing");
    bvalid_hold_a: assert property (bvalid && !bready |=> bvalid)
        else $error("bvalid dropped");

    alarm_c: cover property ($rose(coreIrq[0]));
    supply_c: cover property ($rose(coreIrq[7]));
    warm_c: cover property (!warmResetn && coreIrq != 8'h00);
endmodule : wecr_chk

bind wakeup_event_config_regs wecr_chk u_chk (.clk(clk), .resetn(resetn), .warmResetn(warmResetn),
    .powerEvt(powerEvt), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .hostCfgBase(hostCfgBase), .coreIrq(coreIrq));

// [sim/wecr_host_model.sv]
// Purpose: Host-domain event source for the wake-up event registers
// Assumes: Events change just after a rising edge
// Notes:   Pulses last exactly one clock
`timescale 1ns/100ps
module wecr_host_model (
    input  wire logic                 clk,
    output wecr_pkg::wecr_host_evt_t  hostEvt,
    output wecr_pkg::wecr_power_evt_t powerEvt
);
    // Quiet host at time zero
    initial begin
        hostEvt  = '0;
        powerEvt = '0;
    end

    // Raise or drop event bits, or give a one-clock pulse
    task automatic drive(input bit hst, input logic [8:0] m, input bit v, input bit pulse);
        @(posedge clk);
        if (hst)
            hostEvt <= wecr_pkg::wecr_host_evt_t'(v ? (hostEvt | m[5:0]) : (hostEvt & ~m[5:0]));
        else
            powerEvt <= wecr_pkg::wecr_power_evt_t'(v ? (powerEvt | m) : (powerEvt & ~m));
        if (pulse) drive(hst, m, 1'b0, 1'b0);
    endtask : drive
endmodule : wecr_host_model
